// ---- shared/buck3_pkg.sv ----
/*
  Constants for the third buck regulator control register group: register
  addresses, field positions, masks and step timing.
  Assumes a 100 MHz register clock and byte-wide registers on a byte address.
*/
package buck3_pkg;

  // register addresses on the serial control bus
  localparam logic [7:0] ADDR_STANDBY  = 8'h3d;
  localparam logic [7:0] ADDR_SLEEP    = 8'h3e;
  localparam logic [7:0] ADDR_MODE     = 8'h3f;
  localparam logic [7:0] ADDR_CONF     = 8'h40;

  // writable bits of each register, reserved bits are zero here
  localparam logic [7:0] MASK_VOLTAGE  = 8'h1f;
  localparam logic [7:0] MASK_MODE     = 8'h2f;
  localparam logic [7:0] MASK_CONF     = 8'h7d;

  // field positions
  localparam int VOLT_MSB      = 4;
  localparam int MODE_CODE_MSB = 3;
  localparam int TURNOFF_BIT   = 5;
  localparam int STEP_RATE_BIT = 6;
  localparam int PHASE_MSB     = 5;
  localparam int PHASE_LSB     = 4;
  localparam int FREQ_MSB      = 3;
  localparam int FREQ_LSB      = 2;
  localparam int ILIM_BIT      = 0;

  // field widths
  localparam int VOLT_W  = 5;
  localparam int MODE_W  = 4;
  localparam int PHASE_W = 2;
  localparam int FREQ_W  = 2;

  // voltage step timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_FAST_NS  = 2000;
  localparam int STEP_SLOW_NS  = 4000;
  localparam int STEP_FAST_CYC = STEP_FAST_NS / CLK_PERIOD_NS;
  localparam int STEP_SLOW_CYC = STEP_SLOW_NS / CLK_PERIOD_NS;
  localparam int STEP_CNT_W    = 9;

  // regulator operating state
  typedef enum logic [1:0] {
    ST_ON,
    ST_STANDBY,
    ST_SLEEP,
    ST_OFF
  } reg_state_t;

endpackage : buck3_pkg

// ---- shared/otp_load_if.sv ----
/*
  Carries the configuration memory defaults from the loader to the
  register bank, together with the one-cycle load strobe.
  Assumes both ends share mclk_i.
*/
interface otp_load_if;
  import buck3_pkg::*;

  logic               load;
  logic               loaded;
  logic [VOLT_W-1:0]  standby_v;
  logic [VOLT_W-1:0]  sleep_v;
  logic [MODE_W-1:0]  mode_code;
  logic               step_rate;
  logic [FREQ_W-1:0]  freq;
  logic               ilim;

  modport loader (output load, loaded, standby_v, sleep_v, mode_code, step_rate, freq, ilim);
  modport bank   (input  load, loaded, standby_v, sleep_v, mode_code, step_rate, freq, ilim);
endinterface : otp_load_if

// ---- design/otp_defaults_loader.sv ----
/*
  Captures the configuration memory defaults after reset release and hands
  them to the register bank with a single load strobe.
  Assumes the memory outputs are stable and on the mclk_i domain.
*/
module otp_defaults_loader
  import buck3_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // configuration memory image
  input  wire logic [VOLT_W-1:0] otp_standby_v_i,
  input  wire logic [VOLT_W-1:0] otp_sleep_v_i,
  input  wire logic [MODE_W-1:0] otp_mode_code_i,
  input  wire logic              otp_step_rate_i,
  input  wire logic [FREQ_W-1:0] otp_freq_i,
  input  wire logic              otp_ilim_i,
  // defaults towards the bank
  otp_load_if.loader             ld
);

  typedef enum logic [1:0] {LD_CAPTURE, LD_APPLY, LD_DONE} load_state_t;

  load_state_t       state_ff, nxt_state;
  logic [VOLT_W-1:0] stby_ff, sleep_ff;
  logic [MODE_W-1:0] mode_ff;
  logic              rate_ff, ilim_ff;
  logic [FREQ_W-1:0] freq_ff;

  // sequence: capture once after release, then apply
  always_comb begin
    case (state_ff)
      LD_CAPTURE: nxt_state = LD_APPLY;
      LD_APPLY:   nxt_state = LD_DONE;
      default:    nxt_state = LD_DONE;
    endcase
  end

  // straps caught by the clock, never by the reset itself
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_ff <= LD_CAPTURE;
    end else begin
      state_ff <= nxt_state;
    end
    if (!reset_i && state_ff == LD_CAPTURE) begin
      stby_ff  <= otp_standby_v_i;
      sleep_ff <= otp_sleep_v_i;
      mode_ff  <= otp_mode_code_i;
      rate_ff  <= otp_step_rate_i;
      freq_ff  <= otp_freq_i;
      ilim_ff  <= otp_ilim_i;
    end
  end

  assign ld.load      = (state_ff == LD_APPLY);
  assign ld.loaded    = (state_ff == LD_DONE);
  assign ld.standby_v = stby_ff;
  assign ld.sleep_v   = sleep_ff;
  assign ld.mode_code = mode_ff;
  assign ld.step_rate = rate_ff;
  assign ld.freq      = freq_ff;
  assign ld.ilim      = ilim_ff;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_load_single_pulse: assert property (ld.load |=> !ld.load [*8])
    else $error("configuration defaults applied more than once");

endmodule : otp_defaults_loader

// ---- design/voltage_step_timer.sv ----
/*
  Moves the applied output voltage code one step at a time towards its
  target, one step per fast or slow interval.
  Assumes target and rate come from registers on mclk_i.
*/
module voltage_step_timer
  import buck3_pkg::*;
#(
  parameter int FAST_CYC = STEP_FAST_CYC,
  parameter int SLOW_CYC = STEP_SLOW_CYC
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // control
  input  wire logic              slow_i,
  input  wire logic              hold_i,
  input  wire logic [VOLT_W-1:0] target_i,
  // applied code
  output logic [VOLT_W-1:0]      code_o,
  output logic                   busy_o
);

  logic [STEP_CNT_W-1:0] cnt_ff, nxt_cnt, limit;
  logic [VOLT_W-1:0]     code_ff, nxt_code;
  logic                  tick;

  // interval chosen live, so a rate change takes effect at the next tick
  always_comb begin
    limit    = slow_i ? STEP_CNT_W'(SLOW_CYC - 1) : STEP_CNT_W'(FAST_CYC - 1);
    tick     = (cnt_ff >= limit);
    nxt_cnt  = tick ? '0 : cnt_ff + 1'b1;
    nxt_code = code_ff;
    if (tick && !hold_i) begin
      if (code_ff < target_i) begin
        nxt_code = code_ff + 1'b1;
      end else if (code_ff > target_i) begin
        nxt_code = code_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_ff  <= '0;
      code_ff <= '0;
    end else begin
      cnt_ff  <= nxt_cnt;
      code_ff <= nxt_code;
    end
  end

  assign code_o = code_ff;
  assign busy_o = (code_ff != target_i);

  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_step_spacing_min: assert property (tick |=> !tick [*8])
    else $error("voltage steps closer than the interval");
  a_step_one_code: assert property (tick && !hold_i && code_ff != target_i |=>
      (code_ff == $past(code_ff) + 1'b1) || (code_ff == $past(code_ff) - 1'b1))
    else $error("voltage code did not move by exactly one step");
  a_code_steady_between: assert property (!tick |=> code_ff == $past(code_ff))
    else $error("voltage code moved between steps");

endmodule : voltage_step_timer

// ---- design/buck3_control_registers.sv ----
/*
  Control register group of the third buck regulator: standby and sleep
  voltages, switching mode with turn-off target, and configuration.
  Assumes a serial bus slave in front that presents byte reads and writes
  on mclk_i, and configuration memory outputs on the same clock.
*/

// Overview of operation
// - The standby register holds a 5-bit code in bits 4:0 giving the output voltage in standby.
// - The sleep register holds a 5-bit code in bits 4:0 giving the output voltage in sleep mode.
// - Mode bit 5 picks the state after a turn-off event: 0 off, 1 sleep.
// - Mode bits 3:0 hold the 4-bit switching mode code.
// - Configuration bit 6 sets the voltage step rate: 0 one step per 2.0 us, 1 one step per 4.0 us.
// - Configuration bits 5:4 choose the switching clock phase.
// - Configuration bits 3:2 choose the switching frequency.
// - Configuration bit 0 chooses the current limit: 0 about 2.75 A, 1 about 2.0 A.
// - After reset the voltage, mode code, step rate, frequency and current limit fields take their values from configuration memory; phase and turn-off bits clear.
module buck3_control_registers
  import buck3_pkg::*;
#(
  parameter int FAST_CYC = STEP_FAST_CYC,
  parameter int SLOW_CYC = STEP_SLOW_CYC
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // register access from the bus slave
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic [7:0]             reg_rdata_o,
  output logic                   reg_rvalid_o,
  output logic                   reg_ready_o,
  // configuration memory image
  input  wire logic [VOLT_W-1:0] otp_standby_v_i,
  input  wire logic [VOLT_W-1:0] otp_sleep_v_i,
  input  wire logic [MODE_W-1:0] otp_mode_code_i,
  input  wire logic              otp_step_rate_i,
  input  wire logic [FREQ_W-1:0] otp_freq_i,
  input  wire logic              otp_ilim_i,
  // system power events, asynchronous pins
  input  wire logic              standby_i,
  input  wire logic              turnoff_i,
  // normal-run voltage from the neighbouring register
  input  wire logic [VOLT_W-1:0] run_voltage_i,
  // regulator controls
  output logic [VOLT_W-1:0]      voltage_code_o,
  output logic                   voltage_busy_o,
  output reg_state_t             regulator_state_o,
  output logic                   regulator_enable_o,
  output logic [MODE_W-1:0]      switching_mode_code_o,
  output logic                   voltage_step_rate_o,
  output logic [PHASE_W-1:0]     clock_phase_select_o,
  output logic [FREQ_W-1:0]      switching_frequency_select_o,
  output logic                   current_limit_select_o
);

  otp_load_if ld ();

  otp_defaults_loader u_loader (
    .mclk_i          (mclk_i),
    .reset_i         (reset_i),
    .otp_standby_v_i (otp_standby_v_i),
    .otp_sleep_v_i   (otp_sleep_v_i),
    .otp_mode_code_i (otp_mode_code_i),
    .otp_step_rate_i (otp_step_rate_i),
    .otp_freq_i      (otp_freq_i),
    .otp_ilim_i      (otp_ilim_i),
    .ld              (ld.loader)
  );

  // register storage, full byte kept with reserved bits forced low
  logic [7:0] standby_ff, nxt_standby;
  logic [7:0] sleep_ff,   nxt_sleep;
  logic [7:0] mode_ff,    nxt_mode;
  logic [7:0] conf_ff,    nxt_conf;
  logic [7:0] rdata_ff,   nxt_rdata;
  logic       rvalid_ff,  nxt_rvalid;
  logic       wr_ok;

  // writes held off until the defaults land, or the load would eat them
  assign wr_ok = reg_wr_i && ld.loaded;

  // next register values: load first, then host writes
  always_comb begin
    nxt_standby = standby_ff;
    nxt_sleep   = sleep_ff;
    nxt_mode    = mode_ff;
    nxt_conf    = conf_ff;
    if (ld.load) begin
      nxt_standby                        = '0;
      nxt_standby[VOLT_MSB:0]            = ld.standby_v;
      nxt_sleep                          = '0;
      nxt_sleep[VOLT_MSB:0]              = ld.sleep_v;
      nxt_mode                           = '0;
      nxt_mode[MODE_CODE_MSB:0]          = ld.mode_code;
      nxt_conf                           = '0;
      nxt_conf[STEP_RATE_BIT]            = ld.step_rate;
      nxt_conf[FREQ_MSB:FREQ_LSB]        = ld.freq;
      nxt_conf[ILIM_BIT]                 = ld.ilim;
    end else if (wr_ok) begin
      if (reg_addr_i == ADDR_STANDBY) begin
        nxt_standby = reg_wdata_i & MASK_VOLTAGE;
      end else if (reg_addr_i == ADDR_SLEEP) begin
        nxt_sleep = reg_wdata_i & MASK_VOLTAGE;
      end else if (reg_addr_i == ADDR_MODE) begin
        nxt_mode = reg_wdata_i & MASK_MODE;
      end else if (reg_addr_i == ADDR_CONF) begin
        nxt_conf = reg_wdata_i & MASK_CONF;
      end
    end
  end

  // read path, unmapped addresses read as zero
  // data held until the next read, so a slow host can still fetch it
  always_comb begin
    nxt_rvalid = reg_rd_i && ld.loaded;
    nxt_rdata  = rdata_ff;
    if (nxt_rvalid) begin
      if (reg_addr_i == ADDR_STANDBY) begin
        nxt_rdata = standby_ff;
      end else if (reg_addr_i == ADDR_SLEEP) begin
        nxt_rdata = sleep_ff;
      end else if (reg_addr_i == ADDR_MODE) begin
        nxt_rdata = mode_ff;
      end else if (reg_addr_i == ADDR_CONF) begin
        nxt_rdata = conf_ff;
      end else begin
        nxt_rdata = '0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      standby_ff <= '0;
      sleep_ff   <= '0;
      mode_ff    <= '0;
      conf_ff    <= '0;
      rdata_ff   <= '0;
      rvalid_ff  <= 1'b0;
    end else begin
      standby_ff <= nxt_standby;
      sleep_ff   <= nxt_sleep;
      mode_ff    <= nxt_mode;
      conf_ff    <= nxt_conf;
      rdata_ff   <= nxt_rdata;
      rvalid_ff  <= nxt_rvalid;
    end
  end

  assign reg_rdata_o  = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign reg_ready_o  = ld.loaded;

  // pin synchronisers: three stages, a change counts when two and three agree
  // costs a few cycles of latency, but a one-cycle glitch never reaches the state
  logic [1:0] pin_raw;
  logic [1:0] sync1_ff, sync2_ff, sync3_ff;
  logic [1:0] pin_lvl_ff, nxt_pin_lvl;

  assign pin_raw = {turnoff_i, standby_i};

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin_filter
      always_comb begin
        nxt_pin_lvl[gi] = (sync2_ff[gi] == sync3_ff[gi]) ? sync3_ff[gi] : pin_lvl_ff[gi];
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pin_lvl_ff <= '0;
    end else begin
      pin_lvl_ff <= nxt_pin_lvl;
    end
  end

  // operating state: turn-off outranks standby
  // frozen until loaded, so the turn-off target is never read before it is known
  reg_state_t       state_ff, nxt_state;
  logic [VOLT_W-1:0] target_v;

  always_comb begin
    case (1'b1)
      pin_lvl_ff[1]: nxt_state = mode_ff[TURNOFF_BIT] ? ST_SLEEP : ST_OFF;
      pin_lvl_ff[0]: nxt_state = ST_STANDBY;
      default:       nxt_state = ST_ON;
    endcase
    case (state_ff)
      ST_STANDBY: target_v = standby_ff[VOLT_MSB:0];
      ST_SLEEP:   target_v = sleep_ff[VOLT_MSB:0];
      default:    target_v = run_voltage_i;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_ff <= ST_OFF;
    end else if (ld.loaded) begin
      state_ff <= nxt_state;
    end
  end

  // applied voltage ramps, frozen while off so it resumes from the last code
  voltage_step_timer #(
    .FAST_CYC (FAST_CYC),
    .SLOW_CYC (SLOW_CYC)
  ) u_step (
    .mclk_i   (mclk_i),
    .reset_i  (reset_i),
    .slow_i   (conf_ff[STEP_RATE_BIT]),
    .hold_i   (state_ff == ST_OFF),
    .target_i (target_v),
    .code_o   (voltage_code_o),
    .busy_o   (voltage_busy_o)
  );

  // field outputs straight from the register flops
  assign regulator_state_o            = state_ff;
  assign regulator_enable_o           = (state_ff != ST_OFF);
  assign switching_mode_code_o        = mode_ff[MODE_CODE_MSB:0];
  assign voltage_step_rate_o          = conf_ff[STEP_RATE_BIT];
  assign clock_phase_select_o         = conf_ff[PHASE_MSB:PHASE_LSB];
  assign switching_frequency_select_o = conf_ff[FREQ_MSB:FREQ_LSB];
  assign current_limit_select_o       = conf_ff[ILIM_BIT];

  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_standby_write_takes: assert property (wr_ok && reg_addr_i == ADDR_STANDBY |=>
      standby_ff == ($past(reg_wdata_i) & MASK_VOLTAGE))
    else $error("standby voltage write not stored");
  a_sleep_write_takes: assert property (wr_ok && reg_addr_i == ADDR_SLEEP |=>
      sleep_ff == ($past(reg_wdata_i) & MASK_VOLTAGE))
    else $error("sleep voltage write not stored");
  a_turnoff_goes_sleep: assert property (ld.loaded && pin_lvl_ff[1] && mode_ff[TURNOFF_BIT] |=>
      regulator_state_o == ST_SLEEP && regulator_enable_o)
    else $error("turn-off did not enter sleep");
  a_turnoff_goes_off: assert property (ld.loaded && pin_lvl_ff[1] && !mode_ff[TURNOFF_BIT] |=>
      regulator_state_o == ST_OFF && !regulator_enable_o)
    else $error("turn-off did not enter off");
  a_mode_code_readback: assert property (wr_ok && reg_addr_i == ADDR_MODE ##1 !reg_wr_i ##1 reg_rd_i &&
      reg_addr_i == ADDR_MODE |=> reg_rdata_o == ($past(reg_wdata_i, 3) & MASK_MODE))
    else $error("mode register read back differs from write");
  a_conf_fields_out: assert property (wr_ok && reg_addr_i == ADDR_CONF |=>
      clock_phase_select_o == $past(reg_wdata_i[PHASE_MSB:PHASE_LSB]) &&
      switching_frequency_select_o == $past(reg_wdata_i[FREQ_MSB:FREQ_LSB]) &&
      current_limit_select_o == $past(reg_wdata_i[ILIM_BIT]) &&
      voltage_step_rate_o == $past(reg_wdata_i[STEP_RATE_BIT]))
    else $error("configuration fields not driven from write");
  a_otp_defaults_loaded: assert property (ld.load |=>
      standby_ff == {3'h0, $past(ld.standby_v)} && sleep_ff == {3'h0, $past(ld.sleep_v)} &&
      mode_ff == {4'h0, $past(ld.mode_code)} && clock_phase_select_o == 2'h0)
    else $error("configuration defaults not loaded");
  a_reserved_read_zero: assert property (reg_rvalid_o |->
      (reg_rdata_o & ~MASK_VOLTAGE & ~MASK_MODE & ~MASK_CONF) == 8'h00 &&
      !(standby_ff[7:5] != 3'h0 || sleep_ff[7:5] != 3'h0 || mode_ff[7:6] != 2'h0 ||
        mode_ff[4] || conf_ff[7] || conf_ff[1]))
    else $error("reserved bit reads as one");

  // stores land on the taking edge and show in the next cycle, as back-to-back hosts expect
  a_mode_write_takes: assert property (wr_ok && reg_addr_i == ADDR_MODE |=>
      mode_ff == ($past(reg_wdata_i) & MASK_MODE))
    else $error("mode write not stored");
  a_conf_write_takes: assert property (wr_ok && reg_addr_i == ADDR_CONF |=>
      conf_ff == ($past(reg_wdata_i) & MASK_CONF))
    else $error("configuration write not stored");
  a_unmapped_read_zero: assert property (reg_rd_i && ld.loaded && reg_addr_i != ADDR_STANDBY &&
      reg_addr_i != ADDR_SLEEP && reg_addr_i != ADDR_MODE && reg_addr_i != ADDR_CONF |=>
      reg_rvalid_o && reg_rdata_o == 8'h00)
    else $error("unmapped address read not zero");

  // nothing answers before the defaults are in, so no half-loaded bank is seen
  a_read_waits_load: assert property (!ld.loaded |=> !reg_rvalid_o)
    else $error("read answered before defaults loaded");
  a_ready_after_load: assert property (ld.load |=> reg_ready_o)
    else $error("ready not raised after defaults loaded");

  // state and applied code follow the filtered pins
  a_standby_entry: assert property (ld.loaded && !pin_lvl_ff[1] && pin_lvl_ff[0] |=>
      regulator_state_o == ST_STANDBY)
    else $error("standby pin did not enter standby");
  a_off_holds_code: assert property (regulator_state_o == ST_OFF |=>
      voltage_code_o == $past(voltage_code_o))
    else $error("applied code moved while off");

endmodule : buck3_control_registers

// ---- bench/host_bus_model.sv ----
/*
  Behavioural host on the register access face: byte writes and reads.
  Assumes the device clock mclk_i; requests change 1 ns after an edge.
*/
module host_bus_model
  import buck3_pkg::*;
(
  // clock
  input  wire logic       mclk_i,
  // register access towards the device
  output logic [7:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  input  wire logic       reg_ready_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end

  // no request before defaults are loaded, bounded so a dead device cannot hang us
  task automatic wait_ready();
    int n;
    n = 0;
    while (reg_ready_i !== 1'b1 && n < 100) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    @(posedge mclk_i);
    #1;
  endtask : wait_ready

  // one-cycle write strobe; released lines show the inverse, not the old value
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    wait_ready();
    reg_addr_o  = addr;
    reg_wdata_o = data;
    reg_wr_o    = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask : write_reg

  // data and valid are taken in the cycle after the taking edge
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    wait_ready();
    reg_addr_o = addr;
    reg_rd_o   = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_rd_o   = 1'b0;
    reg_addr_o = ~addr;
    ok         = reg_rvalid_i;
    data       = reg_rdata_i;
  endtask : read_reg
endmodule : host_bus_model

// ---- bench/buck3_control_registers_tb.sv ----
/*
  Self-checking bench for the third buck regulator register group.
  Assumes short step intervals (10/20 cycles) and fixed memory defaults except the standby voltage, changed before the second reset.
*/
module buck3_control_registers_tb;
  import buck3_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int FAST = 10;
  localparam int SLOW = 20;

  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, reg_ready;
  logic standby_i = 1'b0;
  logic turnoff_i = 1'b0;
  logic [VOLT_W-1:0] otp_stby = 5'h15;
  logic [VOLT_W-1:0] run_v = 5'h00;
  logic [VOLT_W-1:0] voltage_code;
  logic voltage_busy, regulator_enable, step_rate, ilim;
  reg_state_t regulator_state;
  logic [MODE_W-1:0] mode_code;
  logic [PHASE_W-1:0] phase;
  logic [FREQ_W-1:0] freq;
  logic [7:0] conf_view;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] vals[4] = '{8'hff, 8'h00, 8'ha5, 8'h5a};

  // field outputs folded back into the register layout
  assign conf_view = {1'b0, step_rate, phase, freq, 1'b0, ilim};

  // clock
  always #5 mclk_i = ~mclk_i;

  host_bus_model i_host (
    .mclk_i(mclk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid), .reg_ready_i(reg_ready));

  buck3_control_registers #(.FAST_CYC(FAST), .SLOW_CYC(SLOW)) i_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .reg_ready_o(reg_ready),
    .otp_standby_v_i(otp_stby), .otp_sleep_v_i(5'h0a), .otp_mode_code_i(4'h9), .otp_step_rate_i(1'b1),
    .otp_freq_i(2'h2), .otp_ilim_i(1'b1), .standby_i(standby_i), .turnoff_i(turnoff_i),
    .run_voltage_i(run_v), .voltage_code_o(voltage_code), .voltage_busy_o(voltage_busy),
    .regulator_state_o(regulator_state), .regulator_enable_o(regulator_enable),
    .switching_mode_code_o(mode_code), .voltage_step_rate_o(step_rate), .clock_phase_select_o(phase),
    .switching_frequency_select_o(freq), .current_limit_select_o(ilim));

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_host.read_reg(addr, d, ok);
    check({7'h00, ok}, 8'h01, "read valid");
    check(d, exp, "read data");
  endtask : rd_check

  // pins change after an edge; filtered state settles well within 10 cycles
  task automatic pins(input logic sb, input logic to, input reg_state_t exp);
    @(posedge mclk_i);
    #1;
    standby_i = sb;
    turnoff_i = to;
    repeat (10) @(posedge mclk_i);
    #1;
    check({6'h00, regulator_state}, {6'h00, exp}, "regulator state");
    check({7'h00, regulator_enable}, {7'h00, exp != ST_OFF}, "regulator enable");
  endtask : pins

  // first change syncs to the interval counter, the second gives the exact spacing
  task automatic measure_step(input int exp);
    logic [VOLT_W-1:0] prev;
    int n;
    repeat (2) begin
      prev = voltage_code;
      n = 0;
      do begin
        @(posedge mclk_i);
        #1;
        n++;
      end while (voltage_code === prev && n < 1000);
    end
    check(8'(n), 8'(exp), "step interval");
  endtask : measure_step

  task automatic settle(input logic [VOLT_W-1:0] exp);
    int n;
    n = 0;
    while (voltage_busy !== 1'b0 && n < 2000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    check({3'h0, voltage_code}, {3'h0, exp}, "settled voltage code");
  endtask : settle

  // hang guard, the run needs under two thousand cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      summarize();
    end
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    #1;
    reset_i = 1'b0;
    // defaults from configuration memory, reserved and phase bits zero
    rd_check(ADDR_STANDBY, 8'h15);
    rd_check(ADDR_SLEEP, 8'h0a);
    rd_check(ADDR_MODE, 8'h09);
    rd_check(ADDR_CONF, 8'h49);
    check({4'h0, mode_code}, 8'h09, "mode code output");
    check(conf_view, 8'h49, "conf outputs");
    // four patterns, every code of the 2-bit fields, reserved bits dropped on write
    foreach (vals[i]) begin
      i_host.write_reg(ADDR_STANDBY, vals[i]);
      i_host.write_reg(ADDR_SLEEP, vals[i]);
      i_host.write_reg(ADDR_MODE, vals[i]);
      i_host.write_reg(ADDR_CONF, vals[i]);
      rd_check(ADDR_STANDBY, vals[i] & MASK_VOLTAGE);
      rd_check(ADDR_SLEEP, vals[i] & MASK_VOLTAGE);
      rd_check(ADDR_MODE, vals[i] & MASK_MODE);
      rd_check(ADDR_CONF, vals[i] & MASK_CONF);
      check({4'h0, mode_code}, {4'h0, vals[i][3:0]}, "mode code output");
      check(conf_view, vals[i] & MASK_CONF, "conf outputs");
      check({6'h00, phase}, {6'h00, vals[i][5:4]}, "phase output");
      check({6'h00, freq}, {6'h00, vals[i][3:2]}, "frequency output");
      check({7'h00, ilim}, {7'h00, vals[i][0]}, "current limit output");
    end
    // unmapped address neither stores nor disturbs its neighbour
    i_host.write_reg(8'h41, 8'hff);
    rd_check(8'h41, 8'h00);
    rd_check(ADDR_CONF, 8'h5a & MASK_CONF);
    // ramp to the standby target, fast then slow stepping
    pins(1'b0, 1'b0, ST_ON);
    i_host.write_reg(ADDR_CONF, 8'h00);
    i_host.write_reg(ADDR_STANDBY, 8'h1f);
    pins(1'b1, 1'b0, ST_STANDBY);
    measure_step(FAST);
    i_host.write_reg(ADDR_CONF, 8'h40);
    measure_step(SLOW);
    check({7'h00, voltage_busy}, 8'h01, "ramp in progress");
    settle(5'h1f);
    // turn-off with sleep target, then with off target
    i_host.write_reg(ADDR_SLEEP, 8'h03);
    i_host.write_reg(ADDR_MODE, 8'h20);
    rd_check(ADDR_MODE, 8'h20);
    pins(1'b1, 1'b1, ST_SLEEP);
    settle(5'h03);
    i_host.write_reg(ADDR_MODE, 8'h00);
    pins(1'b1, 1'b1, ST_OFF);
    // back on, ramping from the held code to the normal-run target
    run_v = 5'h09;
    pins(1'b0, 1'b0, ST_ON);
    settle(5'h09);
    // second reset with a new memory image, written fields fall back
    otp_stby = 5'h0b;
    reset_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    check({7'h00, reg_ready}, 8'h00, "ready during reset");
    reset_i = 1'b0;
    rd_check(ADDR_STANDBY, 8'h0b);
    rd_check(ADDR_MODE, 8'h09);
    rd_check(ADDR_CONF, 8'h49);
    summarize();
  end
endmodule : buck3_control_registers_tb
